// *** rtl/aeop_pkg.sv ***
// constants, register map and carrier types for the area event output pulser
// Operation
// - on time eight bits, 100 ms steps
// - separate off time, 100 ms steps
// - active output alternates on then off
// - pulse only when both times nonzero
// - target single output or output group
// - bypass output until disarm completes
// - tamper alarm asserts tamper output
// - tamper clears on always armed disarm
// - alarm memory latches until disarm completes
// - count output at zero or maximum
// - count clear chosen by option bit
// - deferral output on warning start
// - deferral clears on arming or cancel
// - warning period 0 to 255 minutes
// - request arming message on keypad group
// - sixteen bit client code, default ffff
// - ffff selects the service client code
// - lock door group before arming starts
package aeop_pkg;

  // ---------------------------------------------------------------
  // events
  // ---------------------------------------------------------------
  localparam int EVT_N = 5;
  localparam int EV_BYPASS = 0;
  localparam int EV_TAMPER = 1;
  localparam int EV_MEMORY = 2;
  localparam int EV_COUNT = 3;
  localparam int EV_DEFER = 4;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_PERIOD_MS = 100;
  localparam int TICK_CYCLES_DFLT = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [9:0] TICKS_PER_MIN = 10'd600;
  localparam logic [15:0] CLIENT_FALLBACK = 16'hffff;

  // ---------------------------------------------------------------
  // register map, word indices of 32-bit words, byte address is four times the index
  // ---------------------------------------------------------------
  localparam int REG_RW_N = 9;
  localparam logic [7:0] ADR_EVT0 = 8'h00;
  localparam logic [3:0] IDX_DEFER = 4'h5;
  localparam logic [3:0] IDX_CLIENT = 4'h6;
  localparam logic [3:0] IDX_DOOR = 4'h7;
  localparam logic [3:0] IDX_MAXCNT = 4'h8;
  localparam logic [3:0] IDX_STATUS = 4'h9;
  localparam logic [3:0] IDX_REMAIN = 4'ha;
  // event word fields
  localparam int F_ON_LSB = 0;
  localparam int F_OFF_LSB = 8;
  localparam int F_TGT_LSB = 16;
  localparam int F_GRP_BIT = 24;
  localparam logic [31:0] MASK_EVT = 32'h01ff_ffff;
  localparam logic [31:0] MASK_DEFER = 32'h0000_ffff;
  localparam logic [31:0] MASK_CLIENT = 32'h0000_ffff;
  localparam logic [31:0] MASK_DOOR = 32'h0000_01ff;
  localparam logic [31:0] MASK_MAXCNT = 32'h0000_ffff;
  localparam int F_CNT_MODE_BIT = 8;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] RST_CLIENT = 32'h0000_ffff;

  // one event output as seen by the output driver fabric
  typedef struct packed {
    logic drive;
    logic group;
    logic [7:0] target;
  } aeop_evt_s;

  typedef enum logic [2:0] {
    PS_IDLE = 3'b001,
    PS_HIGH = 3'b010,
    PS_LOW = 3'b100
  } aeop_pstate_e;

endpackage

// *** rtl/aeop_top.sv ***
// area event output pulser: pulse engines, event latches, deferral, arming lock and bus
module aeop_pulser
  import aeop_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // control
  input wire logic active_i,
  input wire logic tick_i,
  input wire logic [7:0] on_i,
  input wire logic [7:0] off_i,
  // drive
  output logic level_o
);

  aeop_pstate_e st_q, st_d;
  logic [7:0] cnt_q, cnt_d;
  logic level_q;
  logic pulse_en;

  // both times must be nonzero, otherwise the output holds steady
  assign pulse_en = (on_i != 8'h00) && (off_i != 8'h00);

  // phase sequencing, counters step once per 100 ms tick
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    case (st_q)
      PS_IDLE: begin
        if (active_i) begin
          st_d = PS_HIGH;
          cnt_d = on_i;
        end
      end
      PS_HIGH: begin
        if (!active_i) begin
          st_d = PS_IDLE;
        end else if (pulse_en && tick_i) begin
          if (cnt_q <= 8'h01) begin
            st_d = PS_LOW;
            cnt_d = off_i;
          end else begin
            cnt_d = cnt_q - 8'h01;
          end
        end
      end
      PS_LOW: begin
        if (!active_i) begin
          st_d = PS_IDLE;
        end else if (!pulse_en) begin
          st_d = PS_HIGH;
        end else if (tick_i) begin
          if (cnt_q <= 8'h01) begin
            st_d = PS_HIGH;
            cnt_d = on_i;
          end else begin
            cnt_d = cnt_q - 8'h01;
          end
        end
      end
      default: st_d = PS_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q <= PS_IDLE;
      cnt_q <= 8'h00;
      level_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      level_q <= (st_d == PS_HIGH);
    end
  end

  assign level_o = level_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_on_hold;
    @(posedge clock_i) disable iff (!resetn_i)
    (st_q == PS_HIGH) && active_i && pulse_en && tick_i && (cnt_q > 8'h01) |=> level_q;
  endproperty
  a_on_hold: assert property (p_on_hold) else $error("on phase ended early");

  property p_off_to_on;
    @(posedge clock_i) disable iff (!resetn_i)
    (st_q == PS_LOW) && active_i && pulse_en && tick_i && (cnt_q == 8'h01) |=> level_q;
  endproperty
  a_off_to_on: assert property (p_off_to_on) else $error("off phase did not end");

  property p_off_hold;
    @(posedge clock_i) disable iff (!resetn_i)
    (st_q == PS_LOW) && active_i && pulse_en && !tick_i |=> !level_q;
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("off phase broken");

  property p_steady;
    @(posedge clock_i) disable iff (!resetn_i)
    active_i && !pulse_en && level_q ##1 active_i |-> level_q;
  endproperty
  a_steady: assert property (p_steady) else $error("steady output dropped");

  property p_idle;
    @(posedge clock_i) disable iff (!resetn_i)
    !active_i |=> !level_q;
  endproperty
  a_idle: assert property (p_idle) else $error("inactive output driven");

endmodule // aeop_pulser

module aeop_top
  import aeop_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DFLT
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // avalon-mm slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // area conditions
  input wire logic bypass_present_i,
  input wire logic disarm_done_i,
  input wire logic tamper_alarm_i,
  input wire logic always_armed_disarm_done_i,
  input wire logic area_alarm_i,
  input wire logic counting_en_i,
  input wire logic [15:0] user_count_i,
  input wire logic defer_start_i,
  input wire logic defer_cancel_i,
  input wire logic arm_start_i,
  input wire logic arm_request_i,
  input wire logic lock_done_i,
  input wire logic [15:0] service_client_i,
  // event outputs
  output aeop_evt_s [EVT_N-1:0] evt_o,
  // deferral keypad message and arming control
  output logic defer_msg_req_o,
  output logic [7:0] defer_keypad_grp_o,
  output logic defer_expired_o,
  output logic lock_req_o,
  output logic [7:0] lock_door_grp_o,
  output logic arm_go_o,
  output logic [15:0] report_client_o
);

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic [31:0] regs_q [REG_RW_N];
  logic [31:0] rd_q;
  logic wait_q;
  logic [3:0] idx;
  logic [31:0] be_mask, rd_mux, status_w;
  logic rw_hit, wr_do;

  assign idx = address[5:2];
  assign rw_hit = (address[7:6] == 2'b00) && (address[1:0] == 2'b00)
                  && (idx < 4'(REG_RW_N));
  assign be_mask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}},
                    {8{byteenable[0]}}};
  // a write lands at the edge where waitrequest is seen low
  assign wr_do = write && !wait_q && rw_hit;

  function automatic logic [31:0] reg_mask(input logic [3:0] i);
    logic [31:0] m;
    m = MASK_EVT;
    if (i == IDX_DEFER) m = MASK_DEFER;
    if (i == IDX_CLIENT) m = MASK_CLIENT;
    if (i == IDX_DOOR) m = MASK_DOOR;
    if (i == IDX_MAXCNT) m = MASK_MAXCNT;
    return m;
  endfunction

  // one wait state: data is captured at the same edge where waitrequest drops
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wait_q <= 1'b1;
      rd_q <= 32'h0000_0000;
    end else begin
      wait_q <= !((read || write) && wait_q);
      if (read && wait_q) rd_q <= rd_mux;
    end
  end

  // configuration words, client code resets to the fallback value
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < REG_RW_N; i++) regs_q[i] <= RST_ZERO;
      regs_q[IDX_CLIENT] <= RST_CLIENT;
    end else if (wr_do) begin
      regs_q[idx] <= ((regs_q[idx] & ~be_mask) | (writedata & be_mask)) & reg_mask(idx);
    end
  end

  assign readdata = rd_q;
  assign waitrequest = wait_q;

  // ---------------------------------------------------------------
  // 100 ms timebase
  // ---------------------------------------------------------------
  logic [24:0] tdiv_q;
  logic tick_q;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tdiv_q <= 25'h0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (tdiv_q == 25'(TICK_CYCLES - 1));
      tdiv_q <= (tdiv_q == 25'(TICK_CYCLES - 1)) ? 25'h0 : tdiv_q + 25'h1;
    end
  end

  // ---------------------------------------------------------------
  // event latches, set always wins over clear
  // ---------------------------------------------------------------
  logic [EVT_N-1:0] act_q, set_w, clr_w, lvl_w;
  logic cnt_hit, cnt_hit_q, cnt_mode;

  assign cnt_mode = regs_q[IDX_DOOR][F_CNT_MODE_BIT];
  assign cnt_hit = counting_en_i && ((user_count_i == 16'h0000)
                   || (user_count_i == regs_q[IDX_MAXCNT][15:0]));
  assign set_w[EV_BYPASS] = bypass_present_i;
  assign clr_w[EV_BYPASS] = disarm_done_i;
  assign set_w[EV_TAMPER] = tamper_alarm_i;
  assign clr_w[EV_TAMPER] = always_armed_disarm_done_i;
  assign set_w[EV_MEMORY] = area_alarm_i;
  assign clr_w[EV_MEMORY] = disarm_done_i;
  assign set_w[EV_COUNT] = cnt_hit && !cnt_hit_q;
  // mode 0 clears when the count leaves the limit, mode 1 on disarm
  assign clr_w[EV_COUNT] = cnt_mode ? disarm_done_i : !cnt_hit;
  assign set_w[EV_DEFER] = defer_start_i;
  assign clr_w[EV_DEFER] = arm_start_i || defer_cancel_i;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      act_q <= '0;
      cnt_hit_q <= 1'b0;
    end else begin
      act_q <= set_w | (act_q & ~clr_w);
      cnt_hit_q <= cnt_hit;
    end
  end

  // one pulse engine per event
  for (genvar g = 0; g < EVT_N; g++) begin : g_pulse
    aeop_pulser u_pulser (
      .clock_i(clock_i),
      .resetn_i(resetn_i),
      .active_i(act_q[g]),
      .tick_i(tick_q),
      .on_i(regs_q[g][F_ON_LSB +: 8]),
      .off_i(regs_q[g][F_OFF_LSB +: 8]),
      .level_o(lvl_w[g])
    );
  end

  // route each drive to its output or output group
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      evt_o <= '0;
    end else begin
      for (int i = 0; i < EVT_N; i++) begin
        evt_o[i].drive <= lvl_w[i];
        evt_o[i].group <= regs_q[i][F_GRP_BIT];
        evt_o[i].target <= regs_q[i][F_TGT_LSB +: 8];
      end
    end
  end

  // ---------------------------------------------------------------
  // deferral warning timer, counted in whole minutes of ticks
  // ---------------------------------------------------------------
  logic [7:0] min_q;
  logic [9:0] sub_q;
  logic run_q, expire_w;

  assign expire_w = run_q && (min_q == 8'h00);

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      min_q <= 8'h00;
      sub_q <= 10'h0;
      run_q <= 1'b0;
    end else if (defer_start_i) begin
      min_q <= regs_q[IDX_DEFER][7:0];
      sub_q <= 10'h0;
      run_q <= 1'b1;
    end else if (expire_w || clr_w[EV_DEFER]) begin
      run_q <= 1'b0;
    end else if (run_q && tick_q) begin
      sub_q <= (sub_q == TICKS_PER_MIN - 10'h1) ? 10'h0 : sub_q + 10'h1;
      if (sub_q == TICKS_PER_MIN - 10'h1) min_q <= min_q - 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // arming: lock the door group first, then let arming start
  // ---------------------------------------------------------------
  logic lock_q, go_q, arm_req_w, has_door;

  assign has_door = regs_q[IDX_DOOR][7:0] != 8'h00;
  assign arm_req_w = (arm_request_i || expire_w) && !lock_q;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lock_q <= 1'b0;
      go_q <= 1'b0;
    end else begin
      go_q <= (arm_req_w && !has_door) || (lock_q && lock_done_i);
      if (arm_req_w && has_door) lock_q <= 1'b1;
      else if (lock_done_i) lock_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // keypad request, client code and registered outputs
  // ---------------------------------------------------------------
  logic msg_q, exp_q;
  logic [7:0] kgrp_q, dgrp_q;
  logic [15:0] client_q;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      msg_q <= 1'b0;
      exp_q <= 1'b0;
      kgrp_q <= 8'h00;
      dgrp_q <= 8'h00;
      client_q <= CLIENT_FALLBACK;
    end else begin
      msg_q <= act_q[EV_DEFER];
      exp_q <= expire_w;
      kgrp_q <= regs_q[IDX_DEFER][15:8];
      dgrp_q <= regs_q[IDX_DOOR][7:0];
      client_q <= (regs_q[IDX_CLIENT][15:0] == CLIENT_FALLBACK) ? service_client_i
                  : regs_q[IDX_CLIENT][15:0];
    end
  end

  assign defer_msg_req_o = msg_q;
  assign defer_keypad_grp_o = kgrp_q;
  assign defer_expired_o = exp_q;
  assign lock_req_o = lock_q;
  assign lock_door_grp_o = dgrp_q;
  assign arm_go_o = go_q;
  assign report_client_o = client_q;

  // read selection, unmapped words read zero
  assign status_w = {20'h0, lock_q, run_q, lvl_w, act_q};
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (rw_hit) rd_mux = regs_q[idx];
    else if (address == {2'b00, IDX_STATUS, 2'b00}) rd_mux = status_w;
    else if (address == {2'b00, IDX_REMAIN, 2'b00}) rd_mux = {24'h0, min_q};
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_req_seen;
    (read || write) && waitrequest;
  endsequence
  property p_bus_answer;
    @(posedge clock_i) disable iff (!resetn_i)
    s_req_seen |=> !waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

  property p_bypass;
    @(posedge clock_i) disable iff (!resetn_i)
    bypass_present_i |=> act_q[EV_BYPASS];
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass not latched");

  property p_tamper_hold;
    @(posedge clock_i) disable iff (!resetn_i)
    act_q[EV_TAMPER] && disarm_done_i && !always_armed_disarm_done_i |=> act_q[EV_TAMPER];
  endproperty
  a_tamper_hold: assert property (p_tamper_hold) else $error("tamper cleared early");

  property p_memory;
    @(posedge clock_i) disable iff (!resetn_i)
    area_alarm_i ##1 !disarm_done_i |-> act_q[EV_MEMORY] ##1 act_q[EV_MEMORY];
  endproperty
  a_memory: assert property (p_memory) else $error("alarm memory lost");

  property p_defer_clear;
    @(posedge clock_i) disable iff (!resetn_i)
    (arm_start_i || defer_cancel_i) && !defer_start_i |=> !act_q[EV_DEFER] ##1 !msg_q;
  endproperty
  a_defer_clear: assert property (p_defer_clear) else $error("deferral not cleared");

  property p_lock_first;
    @(posedge clock_i) disable iff (!resetn_i)
    lock_q && !lock_done_i |=> !go_q;
  endproperty
  a_lock_first: assert property (p_lock_first) else $error("arming before lock");

  property p_client;
    @(posedge clock_i) disable iff (!resetn_i)
    regs_q[IDX_CLIENT][15:0] == CLIENT_FALLBACK |=> client_q == $past(service_client_i);
  endproperty
  a_client: assert property (p_client) else $error("client fallback wrong");

  property p_count;
    @(posedge clock_i) disable iff (!resetn_i)
    counting_en_i && (user_count_i == 16'h0000) && !cnt_hit_q |=> act_q[EV_COUNT];
  endproperty
  a_count: assert property (p_count) else $error("count event missed");

endmodule // aeop_top

// *** testbench/aeop_field_model.sv ***
// field side model: keypads, indicators and the door lock controller
module aeop_field_model
  import aeop_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // from the pulser
  input wire aeop_evt_s [EVT_N-1:0] evt_i,
  input wire logic msg_req_i,
  input wire logic lock_req_i,
  // keypad and lock setup from the bench
  input wire logic display_en_i,
  input wire logic [7:0] lock_delay_i,
  // answers
  output logic lock_done_o,
  output logic msg_shown_o,
  output logic beeper_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] wait_q;

  // a keypad shows the arming message only where it is enabled to
  assign msg_shown_o = msg_req_i & display_en_i;
  // beeper placed in the deferral output group
  assign beeper_o = evt_i[EV_DEFER].drive;

  // doors report locked after a programmable delay, one cycle pulse
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wait_q <= 8'h00;
      lock_done_o <= 1'b0;
    end else if (lock_req_i && !lock_done_o) begin
      if (wait_q == lock_delay_i) begin
        lock_done_o <= 1'b1;
        wait_q <= 8'h00;
      end else begin
        wait_q <= wait_q + 8'h01;
      end
    end else begin
      lock_done_o <= 1'b0;
      wait_q <= 8'h00;
    end
  end
endmodule // aeop_field_model

// *** testbench/area_event_output_pulser_tb.sv ***
// self-checking bench for the area event output pulser
`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, s); end end
`define PULSE(s) begin @(posedge clock_i); s <= 1'b1; @(posedge clock_i); s <= 1'b0; end
module area_event_output_pulser_tb
  import aeop_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T = 10;
  logic clock_i = 0, resetn_i = 0, read = 0, write = 0;
  logic [7:0] address = 8'h00;
  logic [3:0] byteenable = 4'hf;
  logic [31:0] writedata = 32'h0, readdata, q;
  logic waitrequest, bypass_present_i = 0, disarm_done_i = 0, tamper_alarm_i = 0;
  logic always_armed_disarm_done_i = 0, area_alarm_i = 0, counting_en_i = 0;
  logic defer_start_i = 0, defer_cancel_i = 0, arm_start_i = 0, arm_request_i = 0;
  logic [15:0] user_count_i = 16'h0, service_client_i = 16'h0;
  logic lock_done_i, defer_msg_req_o, defer_expired_o, lock_req_o, arm_go_o;
  logic [7:0] defer_keypad_grp_o, lock_door_grp_o, lock_delay = 8'h14;
  logic [15:0] report_client_o;
  logic disp_en = 0, shown, beep, grp_a[EVT_N];
  aeop_evt_s [EVT_N-1:0] evt_o;
  logic [7:0] on_a[EVT_N], off_a[EVT_N], tgt_a[EVT_N];
  int miscompares = 0, check_count = 0, n_exp = 0, n_go = 0, hi, lo, e;
  int lat[EVT_N] = '{default: 0};
  integer seed = 32'h2ae8;

  aeop_top #(.TICK_CYCLES(T)) DUT (.clock_i(clock_i), .resetn_i(resetn_i), .address(address),
    .read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .bypass_present_i(bypass_present_i),
    .disarm_done_i(disarm_done_i), .tamper_alarm_i(tamper_alarm_i),
    .always_armed_disarm_done_i(always_armed_disarm_done_i), .area_alarm_i(area_alarm_i),
    .counting_en_i(counting_en_i), .user_count_i(user_count_i),
    .defer_start_i(defer_start_i), .defer_cancel_i(defer_cancel_i),
    .arm_start_i(arm_start_i), .arm_request_i(arm_request_i), .lock_done_i(lock_done_i),
    .service_client_i(service_client_i), .evt_o(evt_o), .defer_msg_req_o(defer_msg_req_o),
    .defer_keypad_grp_o(defer_keypad_grp_o), .defer_expired_o(defer_expired_o),
    .lock_req_o(lock_req_o), .lock_door_grp_o(lock_door_grp_o), .arm_go_o(arm_go_o),
    .report_client_o(report_client_o));

  aeop_field_model FM (.clock_i(clock_i), .resetn_i(resetn_i), .evt_i(evt_o),
    .msg_req_i(defer_msg_req_o), .lock_req_i(lock_req_o), .display_en_i(disp_en),
    .lock_delay_i(lock_delay), .lock_done_o(lock_done_i), .msg_shown_o(shown),
    .beeper_o(beep));

  // ----------------------------------------------------------------
  // clock and pulse watchers
  // ----------------------------------------------------------------
  initial begin
    forever #2.5 clock_i = ~clock_i;
  end
  // one-cycle outputs are counted so no pulse slips past a busy thread
  always @(posedge clock_i) begin
    if (defer_expired_o === 1'b1) n_exp++;
    if (arm_go_o === 1'b1) n_go++;
  end

  // ----------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------
  // one avalon transfer; held until waitrequest is seen low at an edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock_i);
    address <= a;
    write <= w;
    read <= !w;
    writedata <= d;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 20) miscompares++;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] x, input string nm);
    bus(1'b0, a, 32'h0);
    `CHK(nm, x, q)
  endtask
  // latched event flags against the bench model
  task stc;
    logic [4:0] el;
    for (int i = 0; i < EVT_N; i++) el[i] = lat[i][0];
    bus(1'b0, {2'b00, IDX_STATUS, 2'b00}, 32'h0);
    `CHK("latched", el, q[4:0])
  endtask
  task automatic waitc(ref int c, input int v, input int lim);
    int n = 0;
    while (c < v && n < lim) begin
      @(posedge clock_i);
      n++;
    end
  endtask
  // wait out the next high phase, then time one low and one high phase
  task meas(input int x);
    int n;
    n = 0;
    while (evt_o[x].drive !== 1'b1 && n < 500) begin @(posedge clock_i); n++; end
    while (evt_o[x].drive === 1'b1 && n < 1000) begin @(posedge clock_i); n++; end
    lo = 0;
    hi = 0;
    while (evt_o[x].drive === 1'b0 && lo < 500) begin @(posedge clock_i); lo++; end
    while (evt_o[x].drive === 1'b1 && hi < 500) begin @(posedge clock_i); hi++; end
  endtask
  task automatic steady(input int x);
    int n = 0;
    repeat (80) begin
      @(posedge clock_i);
      if (evt_o[x].drive !== 1'b1) n++;
    end
    `CHK("steady", 0, n)
  endtask
  // tick phase is free running, so allow one tick of slack
  function automatic logic near(input int v, input int t);
    return v >= (t - 1) * T && v <= (t + 1) * T;
  endfunction

  task tally_and_finish;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #150000;
    miscompares++;
    tally_and_finish;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clock_i);
    resetn_i <= 1'b1;
    service_client_i <= 16'($random(seed));
    rdc(8'h18, RST_CLIENT, "client reg");
    `CHK("fallback code", service_client_i, report_client_o)
    bus(1'b1, 8'h18, 32'h1234);
    repeat (2) @(posedge clock_i);
    `CHK("own code", 16'h1234, report_client_o)
    rdc(8'h3c, 32'h0, "unmapped");
    // bypass gets a zero on time, memory a zero off time
    for (e = 0; e < EVT_N; e++) begin
      on_a[e] = (e == EV_BYPASS) ? 8'h0 : 8'(2 + ($random(seed) & 3));
      off_a[e] = (e == EV_MEMORY) ? 8'h0 : 8'(2 + ($random(seed) & 3));
      tgt_a[e] = 8'($random(seed));
      grp_a[e] = 1'($random(seed));
      bus(1'b1, 8'(e * 4), {7'h0, grp_a[e], tgt_a[e], off_a[e], on_a[e]});
      rdc(8'(e * 4), {7'h0, grp_a[e], tgt_a[e], off_a[e], on_a[e]}, "event word");
      `CHK("target", {grp_a[e], tgt_a[e]}, {evt_o[e].group, evt_o[e].target})
    end
    `PULSE(tamper_alarm_i)
    lat[EV_TAMPER] = 1;
    meas(EV_TAMPER);
    `CHK("on time", 1'b1, near(hi, on_a[EV_TAMPER]))
    `CHK("off time", 1'b1, near(lo, off_a[EV_TAMPER]))
    `PULSE(disarm_done_i)
    stc;
    `PULSE(always_armed_disarm_done_i)
    lat[EV_TAMPER] = 0;
    stc;
    `CHK("tamper drive", 1'b0, evt_o[EV_TAMPER].drive)
    `PULSE(area_alarm_i)
    `PULSE(bypass_present_i)
    lat[EV_MEMORY] = 1;
    lat[EV_BYPASS] = 1;
    steady(EV_MEMORY);
    steady(EV_BYPASS);
    stc;
    `PULSE(disarm_done_i)
    lat[EV_MEMORY] = 0;
    lat[EV_BYPASS] = 0;
    stc;
    // count: maximum, leaving it, zero, then clear on disarm only
    bus(1'b1, 8'h20, 32'h5);
    counting_en_i <= 1'b1;
    user_count_i <= 16'h3;
    @(posedge clock_i) user_count_i <= 16'h5;
    lat[EV_COUNT] = 1;
    stc;
    @(posedge clock_i) user_count_i <= 16'h4;
    lat[EV_COUNT] = 0;
    stc;
    @(posedge clock_i) user_count_i <= 16'h0;
    lat[EV_COUNT] = 1;
    stc;
    bus(1'b1, 8'h1c, 32'h100);
    @(posedge clock_i) user_count_i <= 16'h1;
    stc;
    `PULSE(disarm_done_i)
    lat[EV_COUNT] = 0;
    stc;
    // deferral of one minute ending in a slow door lock
    bus(1'b1, 8'h1c, 32'h05);
    bus(1'b1, 8'h14, 32'h3c01);
    `PULSE(defer_start_i)
    lat[EV_DEFER] = 1;
    stc;
    `CHK("msg req", 1'b1, defer_msg_req_o)
    `CHK("keypad grp", 8'h3c, defer_keypad_grp_o)
    `CHK("shown off", 1'b0, shown)
    @(posedge clock_i) disp_en <= 1'b1;
    @(posedge clock_i);
    `CHK("shown on", 1'b1, shown)
    rdc(8'h28, 32'h1, "minutes left");
    waitc(n_exp, 1, 5500);
    `CHK("early expiry", 0, n_exp)
    waitc(n_exp, 1, 1000);
    `CHK("expiry", 1, n_exp)
    repeat (4) @(posedge clock_i);
    `CHK("lock req", 1'b1, lock_req_o)
    `CHK("door grp", 8'h05, lock_door_grp_o)
    `CHK("go before lock", 0, n_go)
    waitc(n_go, 1, 100);
    `CHK("arm go", 1, n_go)
    `PULSE(arm_start_i)
    lat[EV_DEFER] = 0;
    stc;
    `CHK("msg drop", 1'b0, defer_msg_req_o)
    // cancel stops the warning timer
    `PULSE(defer_start_i)
    `PULSE(defer_cancel_i)
    stc;
    repeat (6600) @(posedge clock_i);
    `CHK("no expiry", 1, n_exp)
    // zero minutes and no door group: prompt arming
    bus(1'b1, 8'h1c, 32'h0);
    bus(1'b1, 8'h14, 32'h3c00);
    `PULSE(defer_start_i)
    waitc(n_go, 2, 20);
    `CHK("zero expiry", 2, n_exp)
    `CHK("prompt go", 2, n_go)
    // a direct arming request with a door group locks first
    bus(1'b1, 8'h1c, 32'h03);
    `PULSE(arm_request_i)
    repeat (2) @(posedge clock_i);
    `CHK("request lock", 1'b1, lock_req_o)
    `CHK("request grp", 8'h03, lock_door_grp_o)
    waitc(n_go, 3, 100);
    `CHK("request go", 3, n_go)
    tally_and_finish;
  end
endmodule // area_event_output_pulser_tb
